// ==== hdl/drp_second_loop_ctrl.sv ====
`timescale 1ns/10ps
module drp_second_loop_ctrl #(
	parameter int NUM_REFS = drp_pkg::NUM_REFS,
	parameter longint MINUTE_CYCLES = drp_pkg::MINUTE_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// failure indicators from the monitors, same clock
	input wire drp_pkg::drp_fail_t [NUM_REFS-1:0] ref_fail_ind,
	// loop control
	output drp_pkg::drp_loop_t loop_state,
	output logic [3:0] active_ref,
	// interrupt
	output logic irq
);
	if (NUM_REFS < 1 || NUM_REFS > 9) begin : g_chk
		$error("reference count must be 1 to 9");
	end

	localparam logic [3:0] REF_LIMIT = 4'(NUM_REFS);

	// -----------------------------------------------------------------
	// bus slave
	// -----------------------------------------------------------------
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [7:0] wr_idx_reg;
	logic [7:0] rd_idx_reg;
	logic [7:0] rd_byte;
	logic acc;
	logic [7:0] wdata;

	// hsize ignored: every transfer is served, only its low byte is written
	assign acc = hsel && hready && htrans[1];
	assign wdata = hwdata[7:0];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
			rd_idx_reg <= 8'h00;
		end else begin
			wr_pend_reg <= acc && hwrite;
			rd_pend_reg <= acc && !hwrite;
			if (acc) begin
				wr_idx_reg <= haddr[9:2];
				rd_idx_reg <= haddr[9:2];
			end
		end
	end

	// one wait state on reads so a preceding write is always seen
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else if (acc && !hwrite) begin
			hreadyout <= 1'b0;
		end else if (rd_pend_reg) begin
			hreadyout <= 1'b1;
			hrdata <= {24'h00_0000, rd_byte};
		end
	end

	// -----------------------------------------------------------------
	// configuration registers
	// -----------------------------------------------------------------
	logic [7:0] revert_reg;
	logic [7:0] mode_reg;
	logic [7:0] fmask_reg;
	logic [3:0] hold_reg;
	logic [7:0] reven_reg;
	logic [2:0] evmask_reg;
	logic [1:0] mode_f;
	logic revert_en;

	assign mode_f = mode_reg[drp_pkg::MODE_HI:0];
	assign revert_en = revert_reg[drp_pkg::REVERT_BIT];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			revert_reg <= drp_pkg::RST_REVERT;
			mode_reg <= drp_pkg::RST_MODE;
			fmask_reg <= drp_pkg::RST_FMASK;
			hold_reg <= drp_pkg::RST_HOLD;
			reven_reg <= drp_pkg::RST_REVEN;
			evmask_reg <= drp_pkg::RST_EVMASK;
		end else if (wr_pend_reg) begin
			case (wr_idx_reg)
				drp_pkg::IDX_REVERT: revert_reg <= wdata;
				drp_pkg::IDX_MODE: mode_reg <= wdata;
				drp_pkg::IDX_FMASK: fmask_reg <= wdata;
				drp_pkg::IDX_HOLD: hold_reg <= wdata[drp_pkg::HOLD_HI:0];
				drp_pkg::IDX_REVEN: reven_reg <= wdata;
				drp_pkg::IDX_EVMASK: evmask_reg <= wdata[2:0];
				default: ;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// reference qualification
	// -----------------------------------------------------------------
	logic min_tick;
	logic [NUM_REFS-1:0] fail_m;
	logic [NUM_REFS-1:0] qual;

	drp_minute_tick #(
		.MINUTE_CYCLES(MINUTE_CYCLES)
	) u_tick (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.tick(min_tick)
	);

	for (genvar g = 0; g < NUM_REFS; g++) begin : g_ref
		assign fail_m[g] = |(ref_fail_ind[g] & fmask_reg[drp_pkg::FMASK_HI:0]);
		drp_restore u_rst (
			.sys_clk(sys_clk),
			.rstn(rstn),
			.fail(fail_m[g]),
			.tick(min_tick),
			.hold_min(hold_reg),
			.avail(qual[g])
		);
	end

	// -----------------------------------------------------------------
	// selection
	// -----------------------------------------------------------------
	logic [3:0] refsel_reg;
	logic [3:0] best;
	logic [3:0] ref_n;
	logic any_q;
	logic cur_ok;
	logic man_ok;
	logic best_rev;
	logic cur_fail_n;
	logic cur_fail_reg;
	drp_pkg::drp_loop_t st_n;

	// lower reference number means higher priority
	always_comb begin
		best = 4'h0;
		for (int i = NUM_REFS - 1; i >= 0; i--) begin
			if (qual[i]) begin
				best = 4'(i);
			end
		end
	end

	assign any_q = |qual;
	assign cur_ok = (active_ref < REF_LIMIT) && qual[active_ref];
	assign man_ok = (refsel_reg < REF_LIMIT) && !fail_m[refsel_reg];
	// per-reference revert bit, none for reference eight
	assign best_rev = (best < 4'h8) && reven_reg[best[2:0]];
	assign cur_fail_n = (loop_state == drp_pkg::ST_NORMAL) &&
		(active_ref < REF_LIMIT) && fail_m[active_ref];

	always_comb begin
		st_n = loop_state;
		ref_n = active_ref;
		case (mode_f)
			drp_pkg::MODE_MAN_NORMAL: begin
				ref_n = refsel_reg;
				st_n = man_ok ? drp_pkg::ST_NORMAL : drp_pkg::ST_HOLDOVER;
			end
			drp_pkg::MODE_MAN_HOLD: st_n = drp_pkg::ST_HOLDOVER;
			drp_pkg::MODE_FREERUN: st_n = drp_pkg::ST_FREERUN;
			drp_pkg::MODE_AUTO: begin
				if (!any_q) begin
					st_n = drp_pkg::ST_HOLDOVER;
				end else if (!cur_ok || loop_state != drp_pkg::ST_NORMAL) begin
					// take best qualified
					// not tracking yet: start from the best, not a stale one
					ref_n = best;
					st_n = drp_pkg::ST_NORMAL;
				end else if (revert_en && best_rev && best < active_ref) begin
					ref_n = best;
					st_n = drp_pkg::ST_NORMAL;
				end else begin
					st_n = drp_pkg::ST_NORMAL;
				end
			end
			default: st_n = drp_pkg::ST_FREERUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			loop_state <= drp_pkg::ST_FREERUN;
			active_ref <= 4'h0;
			cur_fail_reg <= 1'b0;
		end else begin
			loop_state <= st_n;
			active_ref <= ref_n;
			cur_fail_reg <= cur_fail_n;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			refsel_reg <= drp_pkg::RST_REFSEL;
		end else if (mode_f == drp_pkg::MODE_AUTO) begin
			refsel_reg <= ref_n;
		end else if (wr_pend_reg && wr_idx_reg == drp_pkg::IDX_REFSEL) begin
			refsel_reg <= wdata[drp_pkg::REFSEL_HI:0];
		end
	end

	// -----------------------------------------------------------------
	// events and interrupt
	// -----------------------------------------------------------------
	logic [2:0] ev;
	logic [2:0] sts_reg;
	logic [2:0] sts_next;
	logic sts_clr;

	assign ev[drp_pkg::EV_HOLDOVER] = (st_n == drp_pkg::ST_HOLDOVER) &&
		(loop_state != drp_pkg::ST_HOLDOVER);
	assign ev[drp_pkg::EV_SWITCH] = (st_n == drp_pkg::ST_NORMAL) &&
		(loop_state == drp_pkg::ST_NORMAL) && (ref_n != active_ref);
	assign ev[drp_pkg::EV_CURFAIL] = cur_fail_n && !cur_fail_reg;
	assign sts_clr = rd_pend_reg && rd_idx_reg == drp_pkg::IDX_EVT;
	// set beats a clearing read in the same cycle
	assign sts_next = (sts_clr ? 3'h0 : sts_reg) | ev;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sts_reg <= 3'h0;
			irq <= 1'b0;
		end else begin
			sts_reg <= sts_next;
			irq <= |(sts_next & evmask_reg);
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		case (rd_idx_reg)
			drp_pkg::IDX_REVERT: rd_byte = revert_reg;
			drp_pkg::IDX_MODE: rd_byte = mode_reg;
			drp_pkg::IDX_REFSEL: rd_byte = {4'h0, refsel_reg};
			drp_pkg::IDX_FMASK: rd_byte = fmask_reg;
			drp_pkg::IDX_HOLD: rd_byte = {4'h0, hold_reg};
			drp_pkg::IDX_REVEN: rd_byte = reven_reg;
			drp_pkg::IDX_STATUS:
				rd_byte = {1'b0, cur_fail_reg, loop_state, active_ref};
			drp_pkg::IDX_EVT: rd_byte = {5'h00, sts_reg};
			drp_pkg::IDX_EVMASK: rd_byte = {5'h00, evmask_reg};
			default: rd_byte = 8'h00;
		endcase
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_freerun_mode: assert property (
		mode_f == drp_pkg::MODE_FREERUN |=> loop_state == drp_pkg::ST_FREERUN)
		else $error("free-run mode left free-run");
	a_holdover_mode: assert property (
		mode_f == drp_pkg::MODE_MAN_HOLD |=> loop_state == drp_pkg::ST_HOLDOVER)
		else $error("manual holdover not held");
	a_manual_track: assert property (
		mode_f == drp_pkg::MODE_MAN_NORMAL |=> active_ref == $past(refsel_reg))
		else $error("manual mode not tracking selection");
	a_manual_fail: assert property (
		mode_f == drp_pkg::MODE_MAN_NORMAL && !man_ok
		|=> loop_state == drp_pkg::ST_HOLDOVER)
		else $error("manual failure not in holdover");
	a_auto_none: assert property (
		mode_f == drp_pkg::MODE_AUTO && !any_q
		|=> loop_state == drp_pkg::ST_HOLDOVER)
		else $error("no reference but not holdover");
	a_auto_qual: assert property (
		mode_f == drp_pkg::MODE_AUTO && any_q
		|-> (ref_n < REF_LIMIT && qual[ref_n])
		##1 loop_state == drp_pkg::ST_NORMAL)
		else $error("auto mode on unqualified reference");
	a_auto_report: assert property (
		mode_f == drp_pkg::MODE_AUTO |=> refsel_reg == active_ref)
		else $error("selection field not reporting choice");
	a_write_ignored: assert property (
		wr_pend_reg && wr_idx_reg == drp_pkg::IDX_REFSEL &&
		mode_f == drp_pkg::MODE_AUTO |=> refsel_reg == active_ref)
		else $error("write changed auto selection");
	a_nonrevert_keep: assert property (
		mode_f == drp_pkg::MODE_AUTO && !revert_en && cur_ok &&
		loop_state == drp_pkg::ST_NORMAL
		|=> $stable(active_ref))
		else $error("non-revertive switch from good reference");
	a_event_sticky: assert property (
		!sts_clr |=> (sts_reg & $past(sts_reg)) == $past(sts_reg))
		else $error("event bit lost without a read");

	c_auto_switch: cover property (
		mode_f == drp_pkg::MODE_AUTO && ev[drp_pkg::EV_SWITCH]);
	c_auto_holdover: cover property (
		mode_f == drp_pkg::MODE_AUTO && ev[drp_pkg::EV_HOLDOVER]);
	c_revert: cover property (
		mode_f == drp_pkg::MODE_AUTO && revert_en && cur_ok &&
		ref_n != active_ref);
	c_clear_read: cover property (sts_clr && |sts_reg);
endmodule : drp_second_loop_ctrl

// ==== inc/drp_pkg.sv ====
package drp_pkg;
	// -----------------------------------------------------------------
	// sizes
	// -----------------------------------------------------------------
	localparam int NUM_REFS = 9;
	localparam int REF_W = 4;
	localparam int EV_W = 3;
	localparam int REVEN_REFS = 8;

	// -----------------------------------------------------------------
	// register indices, byte address is four times the index
	// -----------------------------------------------------------------
	localparam logic [7:0] IDX_REVERT = 8'h2B;
	localparam logic [7:0] IDX_MODE = 8'h2C;
	localparam logic [7:0] IDX_REFSEL = 8'h2D;
	localparam logic [7:0] IDX_FMASK = 8'h2E;
	localparam logic [7:0] IDX_HOLD = 8'h2F;
	localparam logic [7:0] IDX_REVEN = 8'h30;
	localparam logic [7:0] IDX_STATUS = 8'h40;
	localparam logic [7:0] IDX_EVT = 8'h41;
	localparam logic [7:0] IDX_EVMASK = 8'h42;

	// -----------------------------------------------------------------
	// reset values and field positions
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_REVERT = 8'h04;
	localparam logic [7:0] RST_MODE = 8'h02;
	localparam logic [3:0] RST_REFSEL = 4'h0;
	localparam logic [7:0] RST_FMASK = 8'h3C;
	localparam logic [3:0] RST_HOLD = 4'h0;
	localparam logic [7:0] RST_REVEN = 8'h00;
	localparam logic [2:0] RST_EVMASK = 3'h0;
	localparam int REVERT_BIT = 0;
	localparam int MODE_HI = 1;
	localparam int REFSEL_HI = 3;
	localparam int HOLD_HI = 3;
	localparam int FMASK_HI = 3;
	localparam int EV_HOLDOVER = 0;
	localparam int EV_SWITCH = 1;
	localparam int EV_CURFAIL = 2;

	// -----------------------------------------------------------------
	// mode codes
	// -----------------------------------------------------------------
	localparam logic [1:0] MODE_MAN_NORMAL = 2'h0;
	localparam logic [1:0] MODE_MAN_HOLD = 2'h1;
	localparam logic [1:0] MODE_FREERUN = 2'h2;
	localparam logic [1:0] MODE_AUTO = 2'h3;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam longint SYS_CLK_HZ = 20000000;
	localparam longint MINUTE_S = 60;
	localparam longint MINUTE_CYCLES = SYS_CLK_HZ * MINUTE_S;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {ST_FREERUN, ST_HOLDOVER, ST_NORMAL} drp_loop_t;

	// order matches the failure mask bits 3..0
	typedef struct packed {
		logic precise_frequency_monitor;
		logic guard_soak_timer;
		logic coarse_frequency_monitor;
		logic single_cycle_monitor;
	} drp_fail_t;
endpackage : drp_pkg

// ==== hdl/drp_minute_tick.sv ====
`timescale 1ns/10ps
module drp_minute_tick #(
	parameter longint MINUTE_CYCLES = drp_pkg::MINUTE_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// one-cycle pulse per minute
	output logic tick
);
	if (MINUTE_CYCLES < 1 || MINUTE_CYCLES > 64'h0000_0000_FFFF_FFFF) begin : g_chk
		$error("minute count out of range");
	end

	localparam logic [31:0] LAST = 32'(MINUTE_CYCLES - 1);
	logic [31:0] cnt_reg;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule : drp_minute_tick

// ==== hdl/drp_restore.sv ====
`timescale 1ns/10ps
module drp_restore (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// failure and timing
	input wire logic fail,
	input wire logic tick,
	input wire logic [3:0] hold_min,
	// reference may be selected
	output logic avail
);
	logic [3:0] cnt_reg;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= 4'h0;
			avail <= 1'b0;
		end else if (fail) begin
			cnt_reg <= 4'h0;
			avail <= 1'b0;
		end else if (cnt_reg >= hold_min) begin
			avail <= 1'b1;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 4'h1;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_restore_wait: assert property (
		$rose(avail) |-> $past(cnt_reg) >= $past(hold_min) && !$past(fail))
		else $error("reference restored before its wait");
endmodule : drp_restore

// ==== bench/drp_ref_model.sv ====
`timescale 1ns/10ps
// -----------------------------------------------------------------
// nine reference inputs, seen through their failure monitors
// -----------------------------------------------------------------
module drp_ref_model (
	// clock
	input wire logic sys_clk,
	// per-reference failure indicators, high = failed
	output drp_pkg::drp_fail_t [8:0] fail_ind
);
	drp_pkg::drp_fail_t [8:0] fail_next = '0;
	drp_pkg::drp_fail_t [8:0] fail_cur = '0;

	assign fail_ind = fail_cur;

	// monitors share the loop clock: a command lands one edge after it
	// is given and stays as a level until commanded again
	always @(posedge sys_clk) begin
		fail_cur <= fail_next;
	end

	task automatic set_fail(input logic [8:0] which, input logic [3:0] f);
		for (int n = 0; n < 9; n++) begin
			if (which[n]) begin
				fail_next[n] <= f;
			end
		end
	endtask : set_fail
endmodule : drp_ref_model

// ==== bench/drp_second_loop_ctrl_tb.sv ====
`timescale 1ns/10ps
module drp_second_loop_ctrl_tb;
	// -----------------------------------------------------------------
	// signals
	// -----------------------------------------------------------------
	// short minute keeps the fault-free wait inside a short run
	localparam longint MIN_CYC = 20;
	logic sys_clk, rstn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] active_ref;
	wire hready;
	drp_pkg::drp_loop_t loop_state;
	drp_pkg::drp_fail_t [8:0] fail_ind;
	int errors, comparisons;

	assign hready = hreadyout;

	drp_second_loop_ctrl #(.MINUTE_CYCLES(MIN_CYC)) u_dut (
		.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .ref_fail_ind(fail_ind), .loop_state(loop_state),
		.active_ref(active_ref), .irq(irq)
	);

	drp_ref_model u_refs (.sys_clk(sys_clk), .fail_ind(fail_ind));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [7:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'h0};
		do @(posedge sys_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick

	task automatic chk_reg(input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		comparisons++;
		if (rd !== {24'h0, e}) begin
			errors++;
			$display("wrong value at %0t: reg %h gave %h", $time, idx, rd);
		end
	endtask : chk_reg

	// a reference of F means the tracked reference is not looked at
	task automatic chk_loop(input drp_pkg::drp_loop_t st,
		input logic [3:0] r);
		comparisons++;
		if (loop_state !== st || (r !== 4'hF && active_ref !== r)) begin
			errors++;
			$display("wrong value at %0t: loop %0d ref %0d", $time,
				loop_state, active_ref);
		end
	endtask : chk_loop

	task automatic chk_bit(input logic v, input logic e);
		comparisons++;
		if (v !== e) begin
			errors++;
			$display("wrong value at %0t: flag %b", $time, v);
		end
	endtask : chk_bit

	task automatic give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	// -----------------------------------------------------------------
	// watchdog
	// -----------------------------------------------------------------
	initial begin
		repeat (3000) @(posedge sys_clk);
		errors++;
		$display("wrong value at %0t: run hung", $time);
		give_verdict();
	end

	// -----------------------------------------------------------------
	// tests
	// -----------------------------------------------------------------
	initial begin
		errors = 0;
		comparisons = 0;
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		tick(1);
		chk_loop(drp_pkg::ST_FREERUN, 4'h0);
		chk_reg(drp_pkg::IDX_REVERT, drp_pkg::RST_REVERT);
		chk_reg(drp_pkg::IDX_MODE, drp_pkg::RST_MODE);
		chk_reg(drp_pkg::IDX_REFSEL, 8'h00);
		chk_reg(drp_pkg::IDX_REVEN, drp_pkg::RST_REVEN);
		chk_reg(8'h10, 8'h00);
		bus(1'b1, drp_pkg::IDX_REVERT, 8'h05);
		chk_reg(drp_pkg::IDX_REVERT, 8'h05);
		bus(1'b1, drp_pkg::IDX_MODE, 8'h00);
		for (int r = 3; r <= 8; r += 5) begin
			bus(1'b1, drp_pkg::IDX_REFSEL, r[7:0]);
			tick(3);
			chk_loop(drp_pkg::ST_NORMAL, r[3:0]);
		end
		u_refs.set_fail(9'h100, 4'h1);
		tick(4);
		chk_loop(drp_pkg::ST_NORMAL, 4'h8);
		bus(1'b1, drp_pkg::IDX_FMASK, 8'h3D);
		tick(3);
		chk_loop(drp_pkg::ST_HOLDOVER, 4'hF);
		u_refs.set_fail(9'h100, 4'h0);
		bus(1'b1, drp_pkg::IDX_MODE, 8'h01);
		tick(3);
		chk_loop(drp_pkg::ST_HOLDOVER, 4'hF);
		bus(1'b1, drp_pkg::IDX_MODE, 8'h02);
		tick(3);
		chk_loop(drp_pkg::ST_FREERUN, 4'hF);
		bus(1'b1, drp_pkg::IDX_MODE, 8'h03);
		tick(3);
		chk_loop(drp_pkg::ST_NORMAL, 4'h0);
		bus(1'b1, drp_pkg::IDX_REFSEL, 8'h05);
		chk_bit(hresp, 1'b0);
		chk_reg(drp_pkg::IDX_REFSEL, 8'h00);
		u_refs.set_fail(9'h003, 4'h8);
		tick(4);
		chk_loop(drp_pkg::ST_NORMAL, 4'h2);
		chk_reg(drp_pkg::IDX_REFSEL, 8'h02);
		u_refs.set_fail(9'h003, 4'h0);
		tick(4);
		chk_loop(drp_pkg::ST_NORMAL, 4'h2);
		bus(1'b1, drp_pkg::IDX_REVEN, 8'h02);
		tick(3);
		chk_loop(drp_pkg::ST_NORMAL, 4'h2);
		bus(1'b1, drp_pkg::IDX_REVERT, 8'h04);
		bus(1'b1, drp_pkg::IDX_REVEN, 8'h01);
		tick(3);
		chk_loop(drp_pkg::ST_NORMAL, 4'h2);
		bus(1'b1, drp_pkg::IDX_REVERT, 8'h05);
		tick(3);
		chk_loop(drp_pkg::ST_NORMAL, 4'h0);
		// earlier switch, failure and holdover events, cleared by the read
		chk_reg(drp_pkg::IDX_EVT, 8'h07);
		bus(1'b1, drp_pkg::IDX_HOLD, 8'h02);
		u_refs.set_fail(9'h1FF, 4'h8);
		tick(4);
		chk_loop(drp_pkg::ST_HOLDOVER, 4'hF);
		chk_reg(drp_pkg::IDX_STATUS, 8'h10);
		chk_bit(irq, 1'b0);
		bus(1'b1, drp_pkg::IDX_EVMASK, 8'h01);
		tick(2);
		chk_bit(irq, 1'b1);
		bus(1'b0, drp_pkg::IDX_EVT, 8'h00);
		chk_bit(rd[drp_pkg::EV_HOLDOVER], 1'b1);
		tick(2);
		chk_bit(irq, 1'b0);
		// wait of two minutes is 20 to 40 cycles here
		u_refs.set_fail(9'h1FF, 4'h0);
		tick(12);
		chk_loop(drp_pkg::ST_HOLDOVER, 4'hF);
		tick(40);
		chk_loop(drp_pkg::ST_NORMAL, 4'h0);
		give_verdict();
	end
endmodule : drp_second_loop_ctrl_tb
